/* File: emi_pkg.sv */
// Constants and types shared by the external memory interface.
// Assumes a 16-bit data-space address and 8-bit data from the CPU side.
package emi_pkg;

   localparam logic [15:0] EMI_EXT_BASE    = 16'h1100;
   localparam logic [15:0] EMI_SECTOR_STEP = 16'h2000;
   localparam logic [15:0] EMI_LEGACY_BASE = 16'h1000;
   localparam logic [1:0]  EMI_WAIT_NONE   = 2'h0;
   localparam logic [1:0]  EMI_WAIT_ONE    = 2'h1;
   localparam logic [1:0]  EMI_WAIT_TWO    = 2'h2;
   localparam logic [1:0]  EMI_WAIT_TWO_P1 = 2'h3;
   localparam logic [2:0]  EMI_SECT_RST    = 3'h0;
   localparam logic [2:0]  EMI_MASK_RST    = 3'h0;
   localparam logic [7:0]  EMI_BYTE_RST    = 8'h00;
   localparam logic [1:0]  EMI_CNT_RST     = 2'h0;

   typedef enum logic [2:0] {
      EMI_IDLE,
      EMI_ADDR,
      EMI_STROBE,
      EMI_WAIT,
      EMI_END,
      EMI_HOLD
   } emi_state_t;

endpackage

/* File: emi_wait_sel.sv */
// Picks the wait-state code of the sector that holds an external address.
// Assumes the address is already known to be external.
module emi_wait_sel
   import emi_pkg::*;
(
   // Configuration.
   input  wire logic [2:0]  sector_limit_sel,
   input  wire logic [1:0]  lower_wait_sel,
   input  wire logic [1:0]  upper_sector_wait_sel,
   input  wire logic        legacy_mode,
   // Access address and selected code.
   input  wire logic [15:0] addr,
   output logic      [1:0]  wait_code
);
   logic [15:0] limit;
   logic        upper;

   always_comb
   begin
      limit = 16'(EMI_SECTOR_STEP * 16'(sector_limit_sel));
      upper = (sector_limit_sel == EMI_SECT_RST) || legacy_mode ||
              (addr >= limit);
      if (legacy_mode)
         wait_code = {1'b0, upper_sector_wait_sel[0]};
      else if (upper)
         wait_code = upper_sector_wait_sel;
      else
         wait_code = lower_wait_sel;
   end
endmodule

/* File: emi_ext_mem_if.sv */
// External parallel memory interface: multiplexed low address/data bus,
// high address bus, latch strobe and read/write strobes.
// Assumes a CPU request port on sys_clk and pins with per-pin enables.
//
// Summary of operation
// - Enabled interface owns direction of all its dedicated pins.
// - Interface decides internal versus external and drives pins itself.
// - Low address byte is valid on the bus when latch strobe falls.
// - Latch strobe stays low through the whole data transfer phase.
// - Internal accesses may show bus activity, strobes stay inactive.
// - Disabled interface returns pins to port; no aliasing above SRAM.
// - Four wait-state settings, including zero wait.
// - Two sectors, each with its own wait-state selection.
// - Bus keeper holds last level when the bus would float.
// - Bus pull-ups follow the port output bits set to one.
// - Trailing latch pulse only if next access targets RAM.
// - Low address and data share one bus; high byte separate.
// - Number of driven high address lines is configurable.
// - Legacy mode: extended controls gone, upper wait only 00 or 01.
// - Legacy mode: fixed high lines, no sectors, no bus keeper.
// - Legacy mode: read, write and latch pins are outputs only.
// - Wait codes: 0, 1, 2 strobe cycles, or 2 plus one idle.
// - Sector limit zero means one sector; else 8 KB steps.
// - Enable bit activates pin functions; clearing restores ports.
module emi_ext_mem_if
   import emi_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // Control bits.
   input  wire logic        ext_mem_enable,
   input  wire logic        legacy_mode,
   input  wire logic [1:0]  lower_wait_sel,
   input  wire logic [1:0]  upper_sector_wait_sel,
   input  wire logic [2:0]  sector_limit_sel,
   input  wire logic [2:0]  high_addr_mask,
   input  wire logic        bus_keeper_en,
   input  wire logic [15:0] int_sram_top,
   // CPU access port.
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [15:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   input  wire logic        next_is_ram,
   output logic             req_ready,
   output logic             rd_valid,
   output logic [7:0]       rd_data,
   // Port fallback values from the general I/O logic.
   input  wire logic [7:0]  port_ad_out,
   input  wire logic [7:0]  port_ad_oe_n,
   input  wire logic [7:0]  port_hi_out,
   input  wire logic [7:0]  port_hi_oe_n,
   input  wire logic [2:0]  port_ctl_out,
   input  wire logic [2:0]  port_ctl_oe_n,
   // Pins.
   input  wire logic [7:0]  addr_data_low_bus_in,
   output logic      [7:0]  addr_data_low_bus_out,
   output logic      [7:0]  addr_data_low_bus_oe_n,
   output logic      [7:0]  addr_data_low_pullup,
   output logic      [7:0]  addr_data_low_keep,
   output logic      [7:0]  addr_high_bus_out,
   output logic      [7:0]  addr_high_bus_oe_n,
   output logic             ale_out,
   output logic             rd_n_out,
   output logic             wr_n_out,
   output logic      [2:0]  ctl_oe_n
);

   /////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      emi_state_t  state;
      logic [1:0]  cnt;
      logic        ext;
      logic        write;
      logic        hold;
      logic        trail;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  ad_sync1;
      logic [7:0]  ad_sync2;
      logic [7:0]  keep;
      logic        ready;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [7:0]  ad_out;
      logic [7:0]  ad_oe_n;
      logic [7:0]  pull;
      logic [7:0]  keep_out;
      logic [7:0]  hi_out;
      logic [7:0]  hi_oe_n;
      logic        ale;
      logic        rd_n;
      logic        wr_n;
      logic [2:0]  c_oe_n;
   } emi_regs_t;

   emi_regs_t   r_ff;
   emi_regs_t   nxt_r;
   logic [1:0]  wait_code;
   logic [15:0] ext_base;
   logic        is_ext;
   logic        keeper;
   logic        drive_ad;
   logic [7:0]  hi_keep;

   emi_wait_sel u_wait_sel (
      .sector_limit_sel      (sector_limit_sel),
      .lower_wait_sel        (lower_wait_sel),
      .upper_sector_wait_sel (upper_sector_wait_sel),
      .legacy_mode           (legacy_mode),
      .addr                  (req_addr),
      .wait_code             (wait_code)
   );

   /////////////////////////////////////////////////////////////////////////

   // High lines kept for addressing: mask value n frees the top n lines.
   // The largest mask value frees every line, not all but one.
   // Legacy mode ignores the mask and keeps all eight lines.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_hi
         assign hi_keep[gi] = legacy_mode ||
                              ((high_addr_mask != 3'h7) &&
                               (32'(gi) <
                                32'(4'h8 - {1'b0, high_addr_mask})));
      end
   endgenerate

   always_comb
   begin
      ext_base = legacy_mode ? EMI_LEGACY_BASE : EMI_EXT_BASE;
      is_ext   = ext_mem_enable && (req_addr >= ext_base) &&
                 (req_addr > int_sram_top);
      keeper   = bus_keeper_en && !legacy_mode;
   end

   /////////////////////////////////////////////////////////////////////////

   // Access walk, one state per system clock:
   // Idle takes the request and raises the latch strobe with the low
   // address on the bus.
   // Addr drops the latch strobe; the external latch holds the address.
   // Strobe keeps read or write low for one cycle plus the wait count.
   // End raises the strobes, hands over read data and may pulse the
   // latch strobe again when the next access goes to memory.
   // Hold adds the idle cycle of the longest wait code.
   // Internal accesses walk Idle, Addr, Strobe and End, with no wait count, no Hold and both strobes high, so
   // the bus shows activity but no external part is selected.
   always_comb
   begin
      nxt_r        = r_ff;
      nxt_r.rvalid = 1'b0;
      nxt_r.ad_sync1 = addr_data_low_bus_in;
      nxt_r.ad_sync2 = r_ff.ad_sync1;
      drive_ad     = 1'b0;
      unique case (r_ff.state)
         EMI_IDLE:
         begin
            nxt_r.ready = 1'b1;
            nxt_r.ale   = 1'b0;
            if (req_valid && r_ff.ready && ext_mem_enable)
            begin
               nxt_r.ready = 1'b0;
               nxt_r.ext   = is_ext;
               nxt_r.write = req_write;
               nxt_r.addr  = req_addr;
               nxt_r.wdata = req_wdata;
               nxt_r.cnt   = is_ext ? wait_code : EMI_WAIT_NONE;
               nxt_r.hold  = is_ext && (wait_code == EMI_WAIT_TWO_P1);
               nxt_r.ale   = 1'b1;
               nxt_r.state = EMI_ADDR;
            end
            else if (req_valid && r_ff.ready)
            begin
               nxt_r.rvalid = !req_write;
               nxt_r.rdata  = EMI_BYTE_RST;
            end
         end
         EMI_ADDR:
         begin
            nxt_r.ale   = 1'b0;
            nxt_r.state = EMI_STROBE;
            nxt_r.rd_n  = !(r_ff.ext && !r_ff.write);
            nxt_r.wr_n  = !(r_ff.ext && r_ff.write);
         end
         EMI_STROBE:
         begin
            if (r_ff.cnt != EMI_CNT_RST && r_ff.cnt != EMI_WAIT_NONE)
            begin
               // Code 11 waits two strobe cycles like code 10; its extra
               // cycle is spent in the hold state after the access.
               nxt_r.cnt = (r_ff.cnt == EMI_WAIT_TWO_P1) ?
                           EMI_WAIT_ONE : r_ff.cnt - 2'h1;
            end
            else
            begin
               nxt_r.rd_n  = 1'b1;
               nxt_r.wr_n  = 1'b1;
               nxt_r.state = EMI_END;
               if (r_ff.ext && !r_ff.write)
               begin
                  nxt_r.rvalid = 1'b1;
                  nxt_r.rdata  = r_ff.ad_sync2;
               end
               else if (!r_ff.ext && !r_ff.write)
               begin
                  nxt_r.rvalid = 1'b1;
                  nxt_r.rdata  = EMI_BYTE_RST;
               end
            end
         end
         EMI_END:
         begin
            nxt_r.ale   = next_is_ram;
            nxt_r.state = r_ff.hold ? EMI_HOLD : EMI_IDLE;
            nxt_r.ready = !r_ff.hold;
         end
         EMI_HOLD:
         begin
            nxt_r.ale   = 1'b0;
            nxt_r.ready = 1'b1;
            nxt_r.state = EMI_IDLE;
         end
         default:
            nxt_r.state = EMI_IDLE;
      endcase

      // Bus drive: address phase always, data phase only for writes.
      unique case (nxt_r.state)
         EMI_ADDR:   drive_ad = 1'b1;
         EMI_STROBE: drive_ad = nxt_r.write;
         default:    drive_ad = 1'b0;
      endcase
      if (!ext_mem_enable)
         nxt_r.state = EMI_IDLE;

      if (ext_mem_enable)
      begin
         nxt_r.ad_out  = (nxt_r.state == EMI_ADDR) ? nxt_r.addr[7:0]
                                                   : nxt_r.wdata;
         nxt_r.ad_oe_n = drive_ad ? EMI_BYTE_RST : 8'hFF;
         for (int i = 0; i < 8; i++)
         begin
            nxt_r.hi_out[i]  = hi_keep[i] ? nxt_r.addr[8 + i]
                                          : port_hi_out[i];
            nxt_r.hi_oe_n[i] = hi_keep[i] ? 1'b0 : port_hi_oe_n[i];
         end
         nxt_r.c_oe_n = 3'h0;
      end
      else
      begin
         nxt_r.ad_out  = port_ad_out;
         nxt_r.ad_oe_n = port_ad_oe_n;
         nxt_r.hi_out  = port_hi_out;
         nxt_r.hi_oe_n = port_hi_oe_n;
         nxt_r.c_oe_n  = legacy_mode ? 3'h0 : port_ctl_oe_n;
         nxt_r.ale     = port_ctl_out[2];
         nxt_r.rd_n    = port_ctl_out[1];
         nxt_r.wr_n    = port_ctl_out[0];
         nxt_r.ready   = 1'b1;
      end

      // Pull-ups only while the bus floats and the port bit is one.
      nxt_r.pull = port_ad_out & nxt_r.ad_oe_n;
      if (!nxt_r.ad_oe_n[0])
         nxt_r.keep = nxt_r.ad_out;
      else if (keeper)
         nxt_r.keep = r_ff.ad_sync2;
      nxt_r.keep_out = keeper ? nxt_r.keep : EMI_BYTE_RST;
   end

   /////////////////////////////////////////////////////////////////////////

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_ff         <= '0;
         r_ff.state   <= EMI_IDLE;
         r_ff.ad_oe_n <= 8'hFF;
         r_ff.hi_oe_n <= 8'hFF;
         r_ff.c_oe_n  <= 3'h7;
         r_ff.rd_n    <= 1'b1;
         r_ff.wr_n    <= 1'b1;
      end
      else
         r_ff <= nxt_r;
   end

   assign req_ready              = r_ff.ready;
   assign rd_valid               = r_ff.rvalid;
   assign rd_data                = r_ff.rdata;
   assign addr_data_low_bus_out  = r_ff.ad_out;
   assign addr_data_low_bus_oe_n = r_ff.ad_oe_n;
   assign addr_data_low_pullup   = r_ff.pull;
   assign addr_data_low_keep     = r_ff.keep_out;
   assign addr_high_bus_out      = r_ff.hi_out;
   assign addr_high_bus_oe_n     = r_ff.hi_oe_n;
   assign ale_out                = r_ff.ale;
   assign rd_n_out               = r_ff.rd_n;
   assign wr_n_out               = r_ff.wr_n;
   assign ctl_oe_n               = r_ff.c_oe_n;

endmodule

/* File: emi_mem_model.sv */
// Behavioural memory behind a transparent address latch.
// Assumes the interface pins as inputs; it has no clock of its own.
module emi_mem_model
(
   // Pins from the interface.
   input  wire logic       ale,
   input  wire logic [7:0] ad,
   input  wire logic [7:0] hi,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   // Level the memory puts on the shared bus.
   output logic      [7:0] q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [7:0] lo;
   logic [7:0] ad_d;
   // Models the latch hold time: the bus change that comes with the
   // falling latch strobe must not reach the latched address.
   assign #1 ad_d = ad;
   always_latch
   begin
      if (ale)
         lo <= ad_d;
   end
   // Only strobe edges time the memory, never the system clock.
   always @(negedge wr_n)
      #2 mem[{hi, lo}] = ad;
   // A released bus shows the inverse of its last level.
   initial q = 8'h5A;
   always @(rd_n)
      q = rd_n ? ~q : mem[{hi, lo}];
endmodule

/* File: emi_chk.sv */
// Timing checks on the external memory interface ports.
// Assumes it is bound to emi_ext_mem_if.
module emi_chk
   import emi_pkg::*;
(
   // Watched ports.
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        ext_mem_enable,
   input wire logic        legacy_mode,
   input wire logic [1:0]  lower_wait_sel,
   input wire logic [1:0]  upper_sector_wait_sel,
   input wire logic [2:0]  sector_limit_sel,
   input wire logic [15:0] int_sram_top,
   input wire logic        req_valid,
   input wire logic        req_write,
   input wire logic [15:0] req_addr,
   input wire logic [7:0]  req_wdata,
   input wire logic        next_is_ram,
   input wire logic        req_ready,
   input wire logic        rd_valid,
   input wire logic [7:0]  addr_data_low_bus_out,
   input wire logic [7:0]  addr_data_low_bus_oe_n,
   input wire logic        ale_out,
   input wire logic        rd_n_out,
   input wire logic        wr_n_out,
   input wire logic [2:0]  ctl_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       take;
   logic [1:0] code, w_ff, up_ff;
   logic [3:0] low_ff;
   logic [7:0] wd_ff, lo_ff;
   assign take = req_valid && req_ready && ext_mem_enable;
   always_comb
   begin
      if (legacy_mode)
         code = {1'b0, upper_sector_wait_sel[0]};
      else if (sector_limit_sel != 3'h0 &&
               req_addr < {sector_limit_sel, 13'h0000})
         code = lower_wait_sel;
      else
         code = upper_sector_wait_sel;
   end
   // Keeps the wait count and data of the access in flight.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         w_ff <= 2'h0;
         wd_ff <= 8'h00;
         lo_ff <= 8'h00;
         low_ff <= 4'h0;
         up_ff <= 2'h0;
      end
      else
      begin
         if (take)
         begin
            w_ff <= code[1] ? 2'h2 : {1'b0, code[0]};
            wd_ff <= req_wdata;
            lo_ff <= req_addr[7:0];
         end
         low_ff <= (!rd_n_out || !wr_n_out) ? low_ff + 4'h1 : 4'h0;
         up_ff <= {up_ff[0], 1'b1};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_end;
      $rose(rd_n_out) || $rose(wr_n_out);
   endsequence
   sequence s_rd;
      take && !req_write && req_addr > int_sram_top &&
         req_addr >= EMI_EXT_BASE;
   endsequence
   addr_out_a: assert property (take |=> ale_out &&
      addr_data_low_bus_oe_n == 8'h00 && addr_data_low_bus_out == lo_ff)
      else $error("low address missing in latch phase");
   ale_xfer_a: assert property ((!rd_n_out || !wr_n_out) |->
      !ale_out) else $error("latch strobe high during transfer");
   int_quiet_a: assert property (
      take && req_addr <= int_sram_top |=> (rd_n_out && wr_n_out)[*4])
      else $error("strobe on internal access");
   strobe_len_a: assert property (s_end |->
      low_ff == {2'h0, w_ff} + 4'h1) else $error("strobe length wrong");
   wr_drive_a: assert property (!wr_n_out |->
      addr_data_low_bus_oe_n == 8'h00 && addr_data_low_bus_out == wd_ff)
      else $error("write data not driven");
   rd_float_a: assert property (!rd_n_out |->
      addr_data_low_bus_oe_n == 8'hFF) else $error("bus driven in read");
   trail_on_a: assert property (s_end ##0 next_is_ram |->
      ##[0:1] ale_out) else $error("trailing latch pulse missing");
   trail_off_a: assert property (s_end ##0 !next_is_ram |->
      !ale_out [*2]) else $error("unexpected trailing latch pulse");
   rd_answer_a: assert property (s_rd |=> !rd_valid ##1 !rd_valid
      ##[1:3] rd_valid) else $error("read answer timing wrong");
   pin_own_a: assert property (ext_mem_enable && up_ff == 2'h3 &&
      $past(ext_mem_enable) |-> ctl_oe_n == 3'h0)
      else $error("control pins not owned");
endmodule
bind emi_ext_mem_if emi_chk chk_u (.sys_clk, .nrst, .ext_mem_enable,
   .legacy_mode, .lower_wait_sel, .upper_sector_wait_sel, .sector_limit_sel,
   .int_sram_top, .req_valid, .req_write, .req_addr, .req_wdata,
   .next_is_ram, .req_ready, .rd_valid, .addr_data_low_bus_out,
   .addr_data_low_bus_oe_n, .ale_out, .rd_n_out, .wr_n_out, .ctl_oe_n);

/* File: tb.sv */
// Self-checking bench for the external memory interface.
// Assumes emi_mem_model on the far side of the pins.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, nrst = 1'b0, ext_mem_enable = 1'b0;
   logic legacy_mode = 1'b0, bus_keeper_en = 1'b1, req_valid = 1'b0;
   logic req_write = 1'b0, next_is_ram = 1'b0;
   logic req_ready, rd_valid, ale_out, rd_n_out, wr_n_out;
   logic [1:0] lower_wait_sel = 2'h0, upper_sector_wait_sel = 2'h0;
   logic [2:0] sector_limit_sel = 3'h0, high_addr_mask = 3'h0, ctl_oe_n;
   logic [2:0] port_ctl_out = 3'h3, port_ctl_oe_n = 3'h5;
   logic [15:0] int_sram_top = 16'h10FF, req_addr = 16'h0000, g_lat, g_slo;
   logic [7:0] req_wdata = 8'h00, port_ad_out = 8'hF0, port_ad_oe_n = 8'h3C;
   logic [7:0] port_hi_out = 8'h96, port_hi_oe_n = 8'hFF, rd_data, mq;
   logic [7:0] addr_data_low_bus_in, addr_data_low_bus_out, g_q, g_hoe;
   logic [7:0] addr_data_low_bus_oe_n, addr_data_low_pullup, g_pu;
   logic [7:0] addr_data_low_keep, addr_high_bus_out, addr_high_bus_oe_n;
   int error_cnt = 0, check_count = 0;
   always #4 sys_clk = ~sys_clk;
   assign addr_data_low_bus_in = (addr_data_low_bus_out &
      ~addr_data_low_bus_oe_n) | (mq & addr_data_low_bus_oe_n);
   emi_ext_mem_if dut_u (.sys_clk, .nrst, .ext_mem_enable, .legacy_mode,
      .lower_wait_sel, .upper_sector_wait_sel, .sector_limit_sel,
      .high_addr_mask, .bus_keeper_en, .int_sram_top, .req_valid,
      .req_write, .req_addr, .req_wdata, .next_is_ram, .req_ready,
      .rd_valid, .rd_data, .port_ad_out, .port_ad_oe_n, .port_hi_out,
      .port_hi_oe_n, .port_ctl_out, .port_ctl_oe_n, .addr_data_low_bus_in,
      .addr_data_low_bus_out, .addr_data_low_bus_oe_n,
      .addr_data_low_pullup, .addr_data_low_keep, .addr_high_bus_out,
      .addr_high_bus_oe_n, .ale_out, .rd_n_out, .wr_n_out, .ctl_oe_n);
   emi_mem_model mem_u (.ale(ale_out), .ad(addr_data_low_bus_out),
      .hi(addr_high_bus_out), .rd_n(rd_n_out), .wr_n(wr_n_out), .q(mq));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string m);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One access, then 19 cycles of watching strobes and the answer.
   task automatic acc(input logic wr, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, d};
      g_lat = 16'h0000;
      g_slo = 16'h0000;
      @(posedge sys_clk);
      #1;
      req_valid = 1'b0;
      for (int k = 1; k < 20; k++)
      begin
         if (k == 1)
            g_hoe = addr_high_bus_oe_n;
         if (!rd_n_out)
            g_pu = addr_data_low_pullup;
         if (!rd_n_out || !wr_n_out)
            g_slo++;
         if (rd_valid === 1'b1)
            {g_lat, g_q} = {16'(k), rd_data};
         @(posedge sys_clk);
         #1;
      end
   endtask
   task automatic t_waits();
      for (int c = 0; c < 4; c++)
      begin
         {lower_wait_sel, upper_sector_wait_sel} = {2'(c), 2'(c)};
         next_is_ram = c[0];
         acc(1'b1, 16'h2300 + 16'(c), 8'hA0 + 8'(c));
         chk(g_slo, (c > 1) ? 16'h3 : 16'(c + 1), "strobe");
         acc(1'b0, 16'h2300 + 16'(c), 8'h00);
         chk(g_lat, (c > 1) ? 16'h5 : 16'(c + 3), "latency");
         chk(g_pu, port_ad_out, "pull-up");
         if (c > 1)
            chk(g_q, 8'hA0 + 8'(c), "read data");
      end
      $display("t_waits done");
   endtask
   task automatic t_sect();
      {lower_wait_sel, upper_sector_wait_sel} = {2'h0, 2'h2};
      sector_limit_sel = 3'h2;
      acc(1'b1, 16'h3FFF, 8'h11);
      chk(g_slo, 16'h1, "lower sector");
      acc(1'b1, 16'h4000, 8'h22);
      chk(g_slo, 16'h3, "upper sector");
      sector_limit_sel = 3'h0;
      acc(1'b1, 16'h1100, 8'h33);
      chk(g_slo, 16'h3, "one sector");
      int_sram_top = 16'h1FFF;
      acc(1'b0, 16'h1800, 8'h00);
      chk(g_slo, 16'h0, "internal");
      int_sram_top = 16'h10FF;
      $display("t_sect done");
   endtask
   task automatic t_mask();
      for (int m = 0; m < 8; m++)
      begin
         high_addr_mask = 3'(m);
         acc(1'b1, 16'h8000, 8'h44);
         chk(g_hoe, (m == 7) ? 8'hFF : 8'(~(8'hFF >> m)), "mask");
      end
      high_addr_mask = 3'h5;
      $display("t_mask done");
   endtask
   task automatic t_leg();
      {legacy_mode, lower_wait_sel, upper_sector_wait_sel} = 5'h13;
      sector_limit_sel = 3'h2;
      acc(1'b1, 16'h3000, 8'h55);
      chk(g_slo, 16'h2, "legacy wait");
      chk(g_hoe, 16'h0, "legacy high lines");
      chk(addr_data_low_keep, 16'h0, "legacy keeper");
      chk(ctl_oe_n, 16'h0, "strobe pins out");
      legacy_mode = 1'b0;
      $display("t_leg done");
   endtask
   task automatic t_dis();
      ext_mem_enable = 1'b0;
      acc(1'b0, 16'h2300, 8'h00);
      chk(g_lat, 16'h1, "disabled answer");
      chk(g_q, 16'h0, "disabled data");
      chk(g_slo, 16'h0, "disabled strobes");
      chk(addr_data_low_bus_oe_n, port_ad_oe_n, "port enables");
      chk(addr_data_low_bus_out, port_ad_out, "port data");
      chk(ctl_oe_n, port_ctl_oe_n, "control enables");
      $display("t_dis done");
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk);
      #1;
      {nrst, ext_mem_enable} = 2'h3;
      t_waits();
      t_sect();
      t_mask();
      t_leg();
      t_dis();
      close_out();
   end
   initial
   begin
      #100000;
      error_cnt++;
      close_out();
   end
endmodule
